// ==== logic/gst_pkg.sv ====
// package: constants, register map and carrier types of the gated sixteen-bit counter
package gst_pkg;
  localparam int          GST_CNT_W      = 16;
  localparam int          GST_ADDR_W     = 4;
  localparam int          GST_DATA_W     = 8;
  localparam int          GST_PRE_W      = 2;
  // register offsets
  localparam logic [3:0]  GST_OFF_LOW    = 4'h0;
  localparam logic [3:0]  GST_OFF_HIGH   = 4'h1;
  localparam logic [3:0]  GST_OFF_CTRL   = 4'h2;
  localparam logic [3:0]  GST_OFF_GATE   = 4'h3;
  localparam logic [3:0]  GST_OFF_STAT   = 4'h4;
  // control register fields
  localparam int          GST_CTRL_RUN   = 0;
  localparam int          GST_CTRL_NSYNC = 2;
  localparam int          GST_CTRL_OSCEN = 3;
  localparam int          GST_CTRL_PRE   = 4;
  localparam int          GST_CTRL_CS    = 6;
  // gate register fields
  localparam int          GST_GATE_POL   = 6;
  localparam int          GST_GATE_EN    = 7;
  localparam int          GST_GATE_SRC   = 0;
  // status register fields
  localparam int          GST_STAT_OVF   = 0;
  localparam int          GST_STAT_GATE  = 1;
  localparam logic [7:0]  GST_CTRL_RST   = 8'h00;
  localparam logic [7:0]  GST_GATE_RST   = 8'h00;
  // clock select codes
  localparam logic [1:0]  GST_CS_INSTR   = 2'h0;
  localparam logic [1:0]  GST_CS_SYS     = 2'h1;
  localparam logic [1:0]  GST_CS_EXT     = 2'h2;
  localparam logic [1:0]  GST_CS_LFOSC   = 2'h3;
  // gate source codes
  localparam logic [1:0]  GST_GS_PIN     = 2'h0;
  localparam logic [1:0]  GST_GS_CMP1    = 2'h1;
  localparam logic [1:0]  GST_GS_CMP2    = 2'h2;
  localparam logic [1:0]  GST_INSTR_DIV  = 2'h3;
  localparam logic [15:0] GST_CNT_MAX    = 16'hFFFF;
  localparam logic [15:0] GST_SYS_STEP   = 16'h0001;

  typedef struct packed {
    logic [GST_ADDR_W-1:0] addr;
    logic [GST_DATA_W-1:0] wdata;
    logic                  wr;
    logic                  rd;
  } gst_bus_t;

  typedef struct packed {
    logic extCount;
    logic gatePin;
    logic cmp1;
    logic cmp2;
    logic lfOsc;
  } gst_pins_t;
endpackage : gst_pkg

// ==== logic/gst_sync.sv ====
// two-flop synchroniser bank for the asynchronous pins
`timescale 1ns/10ps
module gst_sync #(
  parameter int W = 5
) (
  input  wire logic         sys_clk,
  input  wire logic         rst,
  input  wire logic         clkEn,
  input  wire logic [W-1:0] asyncIn,
  output logic      [W-1:0] syncOut
);
  logic [W-1:0] stage1;
  logic [W-1:0] next_stage1;
  logic [W-1:0] next_syncOut;

  always_comb begin
    next_stage1  = clkEn ? asyncIn : stage1;
    next_syncOut = clkEn ? stage1 : syncOut;
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      stage1  <= '0;
      syncOut <= '0;
    end else begin
      stage1  <= next_stage1;
      syncOut <= next_syncOut;
    end
  end
endmodule : gst_sync

// ==== logic/gst_counter.sv ====
// gated sixteen-bit counter with clock select, prescaler, gate and register port
`timescale 1ns/10ps
// Operation
// RL1: sixteen-bit up-counter read as two bytes
// RL2: writing either byte loads the live counter
// RL3: run off stops; gate enable gates counting
// RL4: two-bit select picks one of four sources
// RL5: internal sources advance through the prescaler
// RL6: system clock source adds four per instruction
// RL7: instruction clock advances once per cycle; the code advances it once every four sys_clk cycles
// RL8: external rising edges counted, sync optional; the NSYNC bit is unused and the pin always passes the synchroniser
// RL9: falling edge needed before first counted rise
// RL10: gate from pin or either comparator
// RL11: sleep-capable sources keep counting in sleep
// RL12: board supplies the secondary oscillator crystal
// RL13: wrap from all ones sets overflow flag
module gst_counter
  import gst_pkg::*;
#(
  parameter int CNT_W = GST_CNT_W
) (
  input  wire logic                  sys_clk,
  input  wire logic                  rst,
  input  wire logic                  clkEn,
  input  wire logic                  sleepMode,
  input  wire gst_bus_t              bus,
  input  wire gst_pins_t             pins,
  output logic      [GST_DATA_W-1:0] rdData,
  output logic                       overflow,
  output logic                       counting
);
  logic [4:0]       pinsSync;
  logic             extSync;
  logic             gatePinSync;
  logic             cmp1Sync;
  logic             cmp2Sync;
  logic             lfSync;

  gst_sync #(.W(5)) gst_sync_i (
    .sys_clk (sys_clk),
    .rst     (rst),
    .clkEn   (clkEn),
    .asyncIn ({pins.extCount, pins.gatePin, pins.cmp1, pins.cmp2, pins.lfOsc}),
    .syncOut (pinsSync)
  );
  assign {extSync, gatePinSync, cmp1Sync, cmp2Sync, lfSync} = pinsSync;

  // register state
  logic [7:0]       ctrl;
  logic [7:0]       gateCfg;
  logic [CNT_W-1:0] count;
  logic [1:0]       instrDiv;
  logic [2:0]       preCnt;
  logic             extPrev;
  logic             lfPrev;
  logic             armed;
  logic             ovf;
  logic [7:0]       next_ctrl;
  logic [7:0]       next_gateCfg;
  logic [CNT_W-1:0] next_count;
  logic [1:0]       next_instrDiv;
  logic [2:0]       next_preCnt;
  logic             next_extPrev;
  logic             next_lfPrev;
  logic             next_armed;
  logic             next_ovf;
  logic [7:0]       next_rdData;
  logic             next_counting;

  logic             runBit;
  logic             gateEn;
  logic [1:0]       clkSel;
  logic [1:0]       preSel;
  logic             gateLevel;
  logic             enable;
  logic             srcTick;
  logic             tick;
  logic [CNT_W-1:0] step;
  logic [CNT_W:0]   sum;
  logic             wrLow;
  logic             wrHigh;
  logic             extRise;
  logic             extFall;
  logic             sysSrc;

  function automatic logic [2:0] preLimit(input logic [1:0] sel);
    return (3'h1 << sel) - 3'h1;
  endfunction : preLimit

  function automatic logic pickGate(input logic [1:0] src, input logic pin, input logic c1, input logic c2);
    case (src)
      GST_GS_CMP1: return c1;
      GST_GS_CMP2: return c2;
      default:     return pin;
    endcase
  endfunction : pickGate

  always_comb begin
    runBit    = ctrl[GST_CTRL_RUN];
    clkSel    = ctrl[GST_CTRL_CS +: 2];
    preSel    = ctrl[GST_CTRL_PRE +: GST_PRE_W];
    gateEn    = gateCfg[GST_GATE_EN];
    // gate source may be the pin or a comparator output
    gateLevel = pickGate(gateCfg[GST_GATE_SRC +: 2], gatePinSync, cmp1Sync, cmp2Sync) // RL10
                ^ ~gateCfg[GST_GATE_POL];
    // run=0 wins over everything; gate only matters with its enable set
    enable    = runBit && (!gateEn || gateLevel); // RL3
    wrLow     = bus.wr && (bus.addr == GST_OFF_LOW);
    wrHigh    = bus.wr && (bus.addr == GST_OFF_HIGH);
    extRise   = extSync && !extPrev;
    extFall   = !extSync && extPrev;
    sysSrc    = 1'b0;
    srcTick   = 1'b0;
    // the processor-clocked sources stop during sleep; others keep going
    case (clkSel) // RL4
      GST_CS_INSTR: srcTick = !sleepMode && (instrDiv == GST_INSTR_DIV); // RL7 RL11
      GST_CS_SYS: begin
        srcTick = !sleepMode && (instrDiv == GST_INSTR_DIV);
        sysSrc  = 1'b1;
      end
      GST_CS_LFOSC: srcTick = lfSync && !lfPrev; // RL11
      GST_CS_EXT: srcTick = !ctrl[GST_CTRL_OSCEN] && extRise && armed; // RL8 RL9 RL11
      default: srcTick = 1'b0;
    endcase
    // the system clock source lands four counts at once, so bits 1:0 carry no time
    step = sysSrc ? (GST_SYS_STEP << 2) : GST_SYS_STEP; // RL6
    tick = enable && srcTick && (preCnt == preLimit(preSel)); // RL5
  end

  always_comb begin
    next_ctrl     = ctrl;
    next_gateCfg  = gateCfg;
    next_count    = count;
    next_instrDiv = instrDiv + 2'h1;
    next_preCnt   = preCnt;
    next_extPrev  = extSync;
    next_lfPrev   = lfSync;
    next_armed    = armed;
    next_ovf      = ovf;
    next_rdData   = 8'h00;
    sum           = {1'b0, count} + {1'b0, step};
    if (enable && srcTick) begin
      next_preCnt = (preCnt == preLimit(preSel)) ? 3'h0 : preCnt + 3'h1; // RL5
    end
    if (tick) begin
      next_count = sum[CNT_W-1:0]; // RL1
      if (sum[CNT_W]) begin
        next_ovf = 1'b1; // RL13
      end
    end
    // a falling edge re-arms; disable or byte write disarms
    if (extFall) begin
      next_armed = 1'b1; // RL9
    end
    if (!runBit || wrLow || wrHigh) begin
      next_armed = extFall && !wrLow && !wrHigh && runBit; // RL9
    end
    if (wrLow) begin
      next_count[7:0] = bus.wdata; // RL2
      next_preCnt     = 3'h0;
    end
    if (wrHigh) begin
      next_count[CNT_W-1:8] = bus.wdata; // RL2
      next_preCnt           = 3'h0;
    end
    if (bus.wr && bus.addr == GST_OFF_CTRL) begin
      next_ctrl = bus.wdata;
    end
    if (bus.wr && bus.addr == GST_OFF_GATE) begin
      next_gateCfg = bus.wdata;
    end
    // writing a one clears the flag, but a same-cycle wrap keeps it set
    if (bus.wr && bus.addr == GST_OFF_STAT && bus.wdata[GST_STAT_OVF] && !(tick && sum[CNT_W])) begin
      next_ovf = 1'b0; // RL13
    end
    if (bus.rd) begin
      case (bus.addr)
        GST_OFF_LOW:  next_rdData = count[7:0]; // RL1
        GST_OFF_HIGH: next_rdData = count[CNT_W-1:8];
        GST_OFF_CTRL: next_rdData = ctrl;
        GST_OFF_GATE: next_rdData = gateCfg;
        GST_OFF_STAT: next_rdData = {6'h00, gateLevel, ovf};
        default:      next_rdData = 8'h00;
      endcase
    end
    next_counting = enable;
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      ctrl     <= GST_CTRL_RST;
      gateCfg  <= GST_GATE_RST;
      count    <= '0;
      instrDiv <= 2'h0;
      preCnt   <= 3'h0;
      extPrev  <= 1'b0;
      lfPrev   <= 1'b0;
      armed    <= 1'b0;
      ovf      <= 1'b0;
      rdData   <= 8'h00;
      counting <= 1'b0;
      overflow <= 1'b0;
    end else if (clkEn) begin
      ctrl     <= next_ctrl;
      gateCfg  <= next_gateCfg;
      count    <= next_count;
      instrDiv <= next_instrDiv;
      preCnt   <= next_preCnt;
      extPrev  <= next_extPrev;
      lfPrev   <= next_lfPrev;
      armed    <= next_armed;
      ovf      <= next_ovf;
      rdData   <= next_rdData;
      counting <= next_counting;
      overflow <= next_ovf;
    end
  end

  // checks
  AST_OFF_HOLDS: assert property (@(posedge sys_clk) disable iff (rst) // RL3
    (clkEn && !runBit && !bus.wr) |=> (count == $past(count)))
    else $error("count moved while run bit low");
  AST_WRITE_LOADS: assert property (@(posedge sys_clk) disable iff (rst) // RL2
    (clkEn && wrLow) |=> (count[7:0] == $past(bus.wdata)))
    else $error("low byte write not loaded");
  AST_SYS_STEP4: assert property (@(posedge sys_clk) disable iff (rst) // RL6
    (clkEn && tick && sysSrc && !bus.wr) |=> (count == $past(count) + 16'h0004))
    else $error("system clock source did not add four");
  AST_NO_ARM_NO_COUNT: assert property (@(posedge sys_clk) disable iff (rst) // RL9
    (clkEn && clkSel == GST_CS_EXT && !armed && !bus.wr) |=> (count == $past(count)))
    else $error("external count without prior falling edge");
  AST_GATE_CLOSED: assert property (@(posedge sys_clk) disable iff (rst) // RL10
    (clkEn && gateEn && !gateLevel && !bus.wr) |=> (count == $past(count)))
    else $error("count moved with gate closed");
  AST_WRAP_FLAG: assert property (@(posedge sys_clk) disable iff (rst) // RL13
    (clkEn && tick && count == GST_CNT_MAX && !sysSrc && !bus.wr) |=> (ovf && count == 16'h0000))
    else $error("wrap did not set overflow");
  AST_INSTR_RATE: assert property (@(posedge sys_clk) disable iff (rst) // RL7
    (clkEn && tick && clkSel == GST_CS_INSTR && !bus.wr) |=> (count == $past(count) + GST_SYS_STEP))
    else $error("instruction source did not add one");
  AST_SLEEP_INSTR: assert property (@(posedge sys_clk) disable iff (rst) // RL11
    (sleepMode && clkSel != GST_CS_EXT && clkSel != GST_CS_LFOSC) |-> !tick)
    else $error("processor clock source ticked in sleep");
  AST_HIGH_LOADS: assert property (@(posedge sys_clk) disable iff (rst) // RL2
    (clkEn && wrHigh) |=> (count[CNT_W-1:8] == $past(bus.wdata)))
    else $error("high byte write not loaded");
  AST_FROZEN_HOLDS: assert property (@(posedge sys_clk) disable iff (rst) // RL1
    (!clkEn) |=> (count == $past(count) && ctrl == $past(ctrl)))
    else $error("state moved with clock enable low");
  AST_LF_STEP: assert property (@(posedge sys_clk) disable iff (rst) // RL4
    (clkEn && tick && clkSel == GST_CS_LFOSC && !bus.wr) |=> (count == $past(count) + GST_SYS_STEP))
    else $error("slow oscillator source did not add one");
  AST_EXT_EDGE_ONLY: assert property (@(posedge sys_clk) disable iff (rst) // RL8
    (clkEn && clkSel == GST_CS_EXT && !extRise && !bus.wr) |=> (count == $past(count)))
    else $error("external source counted without a rising edge");
  AST_PRESCALE_HOLD: assert property (@(posedge sys_clk) disable iff (rst) // RL5
    (clkEn && preCnt != preLimit(preSel) && !bus.wr) |=> (count == $past(count)))
    else $error("count moved before the prescaler ran out");
  AST_OSC_BLOCKS: assert property (@(posedge sys_clk) disable iff (rst) // RL4
    (clkEn && clkSel == GST_CS_EXT && ctrl[GST_CTRL_OSCEN] && !bus.wr) |=> (count == $past(count)))
    else $error("pin counted with oscillator enable set");
  AST_OVF_STICKY: assert property (@(posedge sys_clk) disable iff (rst) // RL13
    (clkEn && ovf && !(bus.wr && bus.addr == GST_OFF_STAT)) |=> ovf)
    else $error("overflow flag dropped without a clear");
  AST_OVF_CLEAR: assert property (@(posedge sys_clk) disable iff (rst) // RL13
    (clkEn && bus.wr && bus.addr == GST_OFF_STAT && bus.wdata[GST_STAT_OVF] && !tick) |=> !ovf)
    else $error("overflow flag not cleared");
  AST_OVF_SET_WINS: assert property (@(posedge sys_clk) disable iff (rst) // RL13
    (clkEn && tick && sum[CNT_W]) |=> ovf)
    else $error("wrap lost against a clear");
  AST_RD_IDLE: assert property (@(posedge sys_clk) disable iff (rst) // RL1
    (clkEn && !bus.rd) |=> (rdData == 8'h00))
    else $error("read data not zero outside a read");
  AST_RUN_OFF_IDLE: assert property (@(posedge sys_clk) disable iff (rst) // RL3
    (clkEn && !runBit) |=> !counting)
    else $error("counting shown with run bit low");
  AST_FREE_RUN: assert property (@(posedge sys_clk) disable iff (rst) // RL3
    (clkEn && runBit && !gateEn) |=> counting)
    else $error("free run not counting");
  AST_ARM_ON_FALL: assert property (@(posedge sys_clk) disable iff (rst) // RL9
    (clkEn && extFall && runBit && !wrLow && !wrHigh) |=> armed)
    else $error("falling edge did not arm");
  AST_DISARM: assert property (@(posedge sys_clk) disable iff (rst) // RL9
    (clkEn && (!runBit || wrLow || wrHigh)) |=> !armed)
    else $error("disable or byte write left the counter armed");

  // rate helper: enabled cycles since the last processor-phased tick, saturating so that
  // prescaled or gated gaps all collapse to one value
  localparam logic [2:0] GAP_MAX = 3'h7;
  logic [2:0]       tickGap;
  logic [2:0]       next_tickGap;

  always_comb begin
    next_tickGap = tickGap;
    if (tick && (clkSel == GST_CS_INSTR || clkSel == GST_CS_SYS)) begin
      next_tickGap = 3'h0;
    end else if (tickGap != GAP_MAX) begin
      next_tickGap = tickGap + 3'h1;
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      tickGap <= GAP_MAX;
    end else if (clkEn) begin
      tickGap <= next_tickGap;
    end
  end

  AST_INSTR_GAP: assert property (@(posedge sys_clk) disable iff (rst) // RL7
    (clkEn && tick && clkSel == GST_CS_INSTR) |-> (tickGap == {1'b0, GST_INSTR_DIV} || tickGap == GAP_MAX))
    else $error("instruction source ticked faster than once per instruction");
endmodule : gst_counter

// ==== verif/gst_pin_model.sv ====
// pin-side model: count pin, gate pin, comparators and a free-running slow oscillator
`timescale 1ns/10ps
module gst_pin_model
  import gst_pkg::*;
(
  input  wire logic sys_clk,
  output gst_pins_t pins
);
  logic [2:0] div;

  initial begin
    pins = '0;
    div  = 3'h0;
  end

  // slow source never stops, one rising edge every 16 sys_clk
  always @(posedge sys_clk) begin
    div <= div + 3'h1;
    if (div == 3'h7) pins.lfOsc <= ~pins.lfOsc;
  end

  // each level is held long enough to pass the pin synchronisers
  task automatic setExt(input logic v);
    @(posedge sys_clk) pins.extCount <= v;
    repeat (8) @(posedge sys_clk);
  endtask : setExt

  task automatic pulse(input int n);
    repeat (n) begin
      setExt(1'b0);
      setExt(1'b1);
    end
  endtask : pulse

  task automatic setGate(input logic [2:0] v);
    @(posedge sys_clk);
    pins.gatePin <= v[0];
    pins.cmp1    <= v[1];
    pins.cmp2    <= v[2];
    repeat (8) @(posedge sys_clk);
  endtask : setGate
endmodule : gst_pin_model

// ==== verif/gst_counter_bench.sv ====
// self-checking bench for the gated sixteen-bit counter
`timescale 1ns/10ps
module gst_counter_bench;
  import gst_pkg::*;
  logic        sys_clk;
  logic        rst;
  logic        clkEn;
  logic        sleepMode;
  gst_bus_t    bus;
  gst_pins_t   pins;
  logic [7:0]  rdData;
  logic        overflow;
  logic        counting;
  logic [7:0]  d;
  logic [15:0] cnt;
  int          mismatches;
  int          cmp_count;
  int          cycles;

  gst_counter gst_counter_i (
    .sys_clk   (sys_clk),
    .rst       (rst),
    .clkEn     (clkEn),
    .sleepMode (sleepMode),
    .bus       (bus),
    .pins      (pins),
    .rdData    (rdData),
    .overflow  (overflow),
    .counting  (counting)
  );
  gst_pin_model gst_pin_model_i (
    .sys_clk (sys_clk),
    .pins    (pins)
  );

  initial begin
    sys_clk = 1'b0;
    forever #20 sys_clk = ~sys_clk;
  end

  task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      mismatches++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk

  task automatic wr(input logic [3:0] a, input logic [7:0] v);
    @(posedge sys_clk) bus <= '{addr: a, wdata: v, wr: 1'b1, rd: 1'b0};
    @(posedge sys_clk) bus.wr <= 1'b0;
  endtask : wr

  // read data stand only in the cycle after the strobe
  task automatic rd(input logic [3:0] a, output logic [7:0] v);
    @(posedge sys_clk) bus <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge sys_clk) bus.rd <= 1'b0;
    #1 v = rdData;
  endtask : rd

  task automatic readCnt;
    rd(GST_OFF_LOW, cnt[7:0]);
    rd(GST_OFF_HIGH, cnt[15:8]);
  endtask : readCnt

  task automatic regsAfterReset;
    rd(GST_OFF_CTRL, d);
    chk("ctrl", d, GST_CTRL_RST);
    rd(GST_OFF_GATE, d);
    chk("gate", d, GST_GATE_RST);
    readCnt;
    chk("count", cnt, 16'h0000);
    wr(4'hF, 8'hAA);
    rd(4'hF, d);
    chk("unmapped", d, 8'h00);
    @(posedge sys_clk) #1 chk("rd idle", rdData, 8'h00);
  endtask : regsAfterReset

  task automatic loadBytes;
    wr(GST_OFF_LOW, 8'h34);
    wr(GST_OFF_HIGH, 8'h12);
    readCnt;
    chk("load", cnt, 16'h1234);
    @(posedge sys_clk) clkEn <= 1'b0;
    wr(GST_OFF_LOW, 8'h55);
    @(posedge sys_clk) clkEn <= 1'b1;
    readCnt;
    chk("frozen", cnt, 16'h1234);
  endtask : loadBytes

  task automatic extCount;
    gst_pin_model_i.setExt(1'b0);
    wr(GST_OFF_LOW, 8'h00);
    wr(GST_OFF_HIGH, 8'h00);
    wr(GST_OFF_CTRL, 8'h81);
    gst_pin_model_i.setExt(1'b1);
    readCnt;
    chk("unarmed", cnt, 16'h0000);
    gst_pin_model_i.pulse(3);
    readCnt;
    chk("ext", cnt, 16'h0003);
    gst_pin_model_i.setExt(1'b0);
    wr(GST_OFF_LOW, 8'hFE);
    wr(GST_OFF_HIGH, 8'hFF);
    gst_pin_model_i.setExt(1'b1);
    readCnt;
    chk("after load", cnt, 16'hFFFE);
    gst_pin_model_i.pulse(2);
    readCnt;
    chk("wrap", cnt, 16'h0000);
    chk("ovf pin", overflow, 1'b1);
    rd(GST_OFF_STAT, d);
    chk("ovf bit", d[0], 1'b1);
    wr(GST_OFF_STAT, 8'h01);
    rd(GST_OFF_STAT, d);
    chk("ovf clr", d[0], 1'b0);
    wr(GST_OFF_CTRL, 8'h80);
    gst_pin_model_i.setExt(1'b0);
    wr(GST_OFF_CTRL, 8'h85);
    rd(GST_OFF_CTRL, d);
    chk("ctrl back", d, 8'h85);
    gst_pin_model_i.setExt(1'b1);
    readCnt;
    chk("reenable", cnt, 16'h0000);
    gst_pin_model_i.pulse(1);
    readCnt;
    chk("rearmed", cnt, 16'h0001);
    @(posedge sys_clk) sleepMode <= 1'b1;
    gst_pin_model_i.pulse(1);
    sleepMode <= 1'b0;
    readCnt;
    chk("ext in sleep", cnt, 16'h0002);
    wr(GST_OFF_CTRL, 8'h89);
    gst_pin_model_i.pulse(2);
    readCnt;
    chk("osc blocks pin", cnt, 16'h0002);
    wr(GST_OFF_CTRL, 8'h00);
  endtask : extCount

  task automatic gating;
    for (int s = 0; s < 3; s++) begin
      gst_pin_model_i.setGate(3'b000);
      wr(GST_OFF_GATE, 8'hC0 | 8'(s));
      wr(GST_OFF_CTRL, 8'h01);
      repeat (6) @(posedge sys_clk);
      chk("gate shut", counting, 1'b0);
      gst_pin_model_i.setGate(3'(1 << s));
      chk("gate open", counting, 1'b1);
      wr(GST_OFF_CTRL, 8'h00);
      repeat (4) @(posedge sys_clk);
      chk("run off", counting, 1'b0);
    end
    gst_pin_model_i.setGate(3'b000);
    wr(GST_OFF_GATE, 8'h80);
    wr(GST_OFF_CTRL, 8'h01);
    repeat (4) @(posedge sys_clk);
    chk("low gate open", counting, 1'b1);
    gst_pin_model_i.setGate(3'b001);
    chk("low gate shut", counting, 1'b0);
    rd(GST_OFF_STAT, d);
    chk("gate level", d[1], 1'b0);
    wr(GST_OFF_CTRL, 8'h00);
    wr(GST_OFF_GATE, 8'h00);
    wr(GST_OFF_CTRL, 8'h01);
    repeat (4) @(posedge sys_clk);
    chk("free run", counting, 1'b1);
    wr(GST_OFF_CTRL, 8'h00);
  endtask : gating

  // the counting window is about 402 cycles, so the tolerance covers two ticks of edge phase
  task automatic rate(input logic [7:0] ctl, input logic slp, input int expv, input int tol);
    @(posedge sys_clk) sleepMode <= slp;
    wr(GST_OFF_LOW, 8'h00);
    wr(GST_OFF_HIGH, 8'h00);
    wr(GST_OFF_CTRL, ctl);
    repeat (400) @(posedge sys_clk);
    wr(GST_OFF_CTRL, 8'h00);
    sleepMode <= 1'b0;
    readCnt;
    chk("rate", 16'(cnt >= 16'(expv - tol) && cnt <= 16'(expv + tol)), 16'h0001);
  endtask : rate

  // with the enable low the running counter must not move
  task automatic freezeRun;
    wr(GST_OFF_LOW, 8'h00);
    wr(GST_OFF_HIGH, 8'h00);
    wr(GST_OFF_CTRL, 8'h01);
    @(posedge sys_clk) clkEn <= 1'b0;
    repeat (40) @(posedge sys_clk);
    clkEn <= 1'b1;
    wr(GST_OFF_CTRL, 8'h00);
    readCnt;
    chk("frozen run", 16'(cnt <= 16'h0001), 16'h0001);
  endtask : freezeRun

  // reset in mid-run, with the flag set and the counter running
  task automatic midReset;
    wr(GST_OFF_LOW, 8'hFF);
    wr(GST_OFF_HIGH, 8'hFF);
    wr(GST_OFF_CTRL, 8'h41);
    repeat (8) @(posedge sys_clk);
    chk("sys wrap", overflow, 1'b1);
    rst <= 1'b1;
    @(posedge sys_clk) rst <= 1'b0;
    #1 chk("reset run", counting, 1'b0);
    chk("reset ovf", overflow, 1'b0);
    rd(GST_OFF_CTRL, d);
    chk("reset ctrl", d, GST_CTRL_RST);
    readCnt;
    chk("reset count", cnt, 16'h0000);
  endtask : midReset

  task automatic rates;
    rate(8'h01, 1'b0, 100, 2);
    rate(8'h11, 1'b0, 50, 2);
    rate(8'h31, 1'b0, 12, 2);
    rate(8'h41, 1'b0, 400, 8);
    chk("sys lsb", cnt[1:0], 2'b00);
    rate(8'hC1, 1'b0, 25, 2);
    rate(8'h01, 1'b1, 0, 0);
    rate(8'hC1, 1'b1, 25, 2);
  endtask : rates

  task automatic complete_run;
    $display("checks %0d mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : complete_run

  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 20000) begin
      mismatches++;
      complete_run;
    end
  end

  initial begin
    rst        = 1'b1;
    clkEn      = 1'b1;
    sleepMode  = 1'b0;
    bus        = '0;
    mismatches = 0;
    cmp_count  = 0;
    cycles     = 0;
    repeat (16) @(posedge sys_clk);
    rst <= 1'b0;
    regsAfterReset;
    loadBytes;
    extCount;
    gating;
    freezeRun;
    rates;
    midReset;
    complete_run;
  end
endmodule : gst_counter_bench
